// >>> rtl/deia_unit.sv
`include "deia_cfg.svh"
module deia_unit
  import deia_pkg::*;
(
  input  wire logic                         i_clock,
  input  wire logic                         i_rst,
  input  wire logic [`DEIA_N_RES-1:0]       i_event_or_irq_select_reg,
  input  wire logic [`DEIA_N_RES-1:0]       i_interrupt_clear_reg,
  input  wire logic                         i_watchdog_interrupt_only_flag,
  input  wire deia_instr_t [`DEIA_N_CH-1:0] i_instr,
  input  wire deia_precise_t [`DEIA_N_CH-1:0]   i_precise,
  input  wire deia_imprecise_t [`DEIA_N_CH-1:0] i_imprecise,
  input  wire deia_ldstat_t [`DEIA_N_CH-1:0]    i_ldstat,
  input  wire logic                         i_load_queue_empty,
  input  wire logic                         i_store_queue_empty,
  input  wire logic [`DEIA_N_CH-1:0]        i_kill,
  output logic [`DEIA_N_RES-1:0]            o_irq,
  output logic [`DEIA_N_RES-1:0]            o_event_pending,
  output logic [`DEIA_N_CH-1:0]             o_stall,
  output logic [`DEIA_N_CH-1:0]             o_nop,
  output logic [`DEIA_N_CH-1:0]             o_halt_issue,
  output logic [`DEIA_N_CH-1:0]             o_faulted,
  output logic [`DEIA_N_CH-1:0]             o_stopped,
  output logic [`DEIA_N_CH-1:0]             o_precise_fault,
  output logic [`DEIA_N_CH*`DEIA_PC_W-1:0]  o_fault_pc,
  output logic                              o_abort_irq,
  output logic                              o_lockup
);

  localparam int WD_CYC = (`DEIA_WD_CYCLES < 1) ? 1 : `DEIA_WD_CYCLES;

  function automatic logic [`DEIA_N_RES-1:0] dec_res(
    input logic [`DEIA_RES_W-1:0] res
  );
    dec_res = `DEIA_N_RES'(1) << res;
  endfunction : dec_res

  logic [`DEIA_N_RES-1:0] evt_ff;
  logic [`DEIA_N_RES-1:0] irq_ff;
  logic [`DEIA_N_RES-1:0] nxt_evt;
  logic [`DEIA_N_RES-1:0] nxt_irq;
  logic [`DEIA_N_RES-1:0] sev_vec;
  logic [`DEIA_N_RES-1:0] evt_set;
  logic [`DEIA_N_RES-1:0] evt_clr;
  logic [`DEIA_N_CH-1:0]  precise_hit;
  logic [`DEIA_N_CH-1:0]  imprecise_hit;
  logic [`DEIA_N_CH-1:0]  contrib;
  logic [`DEIA_N_CH-1:0]  stall_ff;
  logic [`DEIA_N_CH-1:0]  consume_ff;
  logic [`DEIA_RES_W-1:0] wres_ff [`DEIA_N_CH];
  deia_chst_t             st_ff [`DEIA_N_CH];
  logic [7:0]             wd_cnt_ff;
  logic                   lock_cond;
  logic                   wd_fire;
  logic                   abort_ff;
  logic                   stopped_any;
  logic                   all_killed;

  // sends from running channels; a no-op replaces an aborting send
  always_comb begin
    sev_vec = '0;
    for (int c = 0; c < `DEIA_N_CH; c++) begin
      if (i_instr[c].sev && st_ff[c] == DEIA_RUN && !precise_hit[c]) begin
        sev_vec = sev_vec | dec_res(i_instr[c].res);
      end
    end
  end

  // events: wakes clear the cycle after the send, consumes the cycle after the wait
  always_comb begin
    evt_clr = '0;
    for (int c = 0; c < `DEIA_N_CH; c++) begin
      if (consume_ff[c]) begin
        evt_clr = evt_clr | dec_res(wres_ff[c]);
      end
      if (stall_ff[c] && evt_ff[wres_ff[c]]) begin
        evt_clr = evt_clr | dec_res(wres_ff[c]);
      end
    end
  end

  // same-cycle send and wait: waiter takes it, nothing left pending
  always_comb begin
    evt_set = sev_vec & ~i_event_or_irq_select_reg;
    for (int c = 0; c < `DEIA_N_CH; c++) begin
      if (i_instr[c].wfe && st_ff[c] == DEIA_RUN && !precise_hit[c]
          && sev_vec[i_instr[c].res]) begin
        evt_set = evt_set & ~dec_res(i_instr[c].res);
      end
    end
  end

  // set beats clear, so a send in the clearing cycle is not lost
  assign nxt_evt = (evt_ff & ~evt_clr) | evt_set;

  // interrupts: set wins over a clear in the same cycle
  always_comb begin
    nxt_irq = (irq_ff & ~i_interrupt_clear_reg)
            | (sev_vec & i_event_or_irq_select_reg);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      evt_ff <= `DEIA_EVT_RST;
    end else begin
      evt_ff <= nxt_evt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_ff <= `DEIA_IRQ_RST;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // lockup watchdog: condition must persist for the timeout
  always_comb begin
    lock_cond = i_load_queue_empty && i_store_queue_empty;
    stopped_any = 1'b0;
    contrib = '0;
    for (int c = 0; c < `DEIA_N_CH; c++) begin
      if (i_ldstat[c].running && st_ff[c] != DEIA_FAULTING
          && st_ff[c] != DEIA_FAULTED) begin
        stopped_any = 1'b1;
        contrib[c] = 1'b1;
        if (!(i_ldstat[c].blocked_fifo || i_ldstat[c].blocked_lock)) begin
          lock_cond = 1'b0;
        end
      end
    end
    lock_cond = lock_cond && stopped_any;
  end

  assign wd_fire = lock_cond && (wd_cnt_ff == 8'(WD_CYC - 1));

  always_ff @(posedge i_clock) begin
    if (i_rst || !lock_cond || wd_fire) begin
      wd_cnt_ff <= 8'h00;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 8'h01;
    end
  end

  // per-channel abort, wait and state tracking
  genvar g;
  generate
    for (g = 0; g < `DEIA_N_CH; g++) begin : g_ch
      logic is_wait;
      logic evt_now;
      logic wd_abort;

      assign precise_hit[g] = (i_precise[g] != '0)
                              && st_ff[g] == DEIA_RUN;
      // irq-only mode reports the lockup but lets channels keep trying
      assign wd_abort = wd_fire && contrib[g]
                        && !i_watchdog_interrupt_only_flag;
      assign imprecise_hit[g] = (i_imprecise[g] != '0)
                                || wd_abort;
      assign is_wait = i_instr[g].wfe && st_ff[g] == DEIA_RUN
                       && !precise_hit[g];
      // pending: one-cycle halt; sent this cycle: no halt at all
      assign evt_now = evt_ff[i_instr[g].res] || sev_vec[i_instr[g].res];

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          st_ff[g] <= DEIA_RUN;
        end else begin
          unique case (st_ff[g])
            DEIA_RUN: begin
              if (precise_hit[g] || imprecise_hit[g]) begin
                st_ff[g] <= DEIA_FAULTING;
              end else if (is_wait && !evt_now) begin
                st_ff[g] <= DEIA_WAIT;
              end
            end
            DEIA_WAIT: begin
              if (imprecise_hit[g]) begin
                st_ff[g] <= DEIA_FAULTING;
              end else if (evt_ff[wres_ff[g]]) begin
                st_ff[g] <= DEIA_RUN;
              end
            end
            DEIA_FAULTING: begin
              if (!i_ldstat[g].bus_active) begin
                st_ff[g] <= DEIA_FAULTED;
              end
            end
            DEIA_FAULTED: begin
              if (i_kill[g]) begin
                st_ff[g] <= DEIA_RUN;
              end
            end
          endcase
        end
      end

      // wait on an already present event consumes it one cycle later
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          consume_ff[g] <= 1'b0;
          wres_ff[g]    <= '0;
        end else begin
          consume_ff[g] <= is_wait && evt_ff[i_instr[g].res];
          if (is_wait) begin
            wres_ff[g] <= i_instr[g].res;
          end
        end
      end

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          stall_ff[g] <= 1'b0;
        end else begin
          stall_ff[g] <= (is_wait && !evt_now)
                         || (stall_ff[g] && !evt_ff[wres_ff[g]]
                             && !imprecise_hit[g]);
        end
      end

      // pc capture; imprecise leaves whatever pc is current
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          o_fault_pc[g*`DEIA_PC_W +: `DEIA_PC_W] <= '0;
          o_precise_fault[g] <= 1'b0;
        end else if (precise_hit[g]) begin
          o_fault_pc[g*`DEIA_PC_W +: `DEIA_PC_W] <= i_instr[g].pc;
          o_precise_fault[g] <= 1'b1;
        end else if (imprecise_hit[g] && st_ff[g] != DEIA_FAULTING
                     && st_ff[g] != DEIA_FAULTED) begin
          o_fault_pc[g*`DEIA_PC_W +: `DEIA_PC_W] <= i_instr[g].pc;
          o_precise_fault[g] <= 1'b0;
        end
      end

      assign o_stall[g] = stall_ff[g] || consume_ff[g]
                          || (is_wait && !evt_now);
      assign o_nop[g] = precise_hit[g];
      assign o_halt_issue[g] = st_ff[g] == DEIA_FAULTING
                               || st_ff[g] == DEIA_FAULTED;
      assign o_faulted[g] = st_ff[g] == DEIA_FAULTED;

      // stopped after a kill until the channel is started again
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          o_stopped[g] <= 1'b0;
        end else if (st_ff[g] == DEIA_FAULTED && i_kill[g]) begin
          o_stopped[g] <= 1'b1;
        end else if (i_ldstat[g].running) begin
          o_stopped[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // last halted channel killed: nothing left for the handler to see
  assign all_killed = (i_kill != '0) && ((o_halt_issue & ~i_kill) == '0);

  // abort irq held until one cycle's kill covers every halted channel, draining ones included
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      abort_ff <= 1'b0;
    end else if (wd_fire || (precise_hit != '0) || (imprecise_hit != '0)) begin
      abort_ff <= 1'b1;
    end else if (all_killed) begin
      abort_ff <= 1'b0;
    end
  end

  assign o_irq           = irq_ff;
  assign o_event_pending = evt_ff;
  assign o_abort_irq     = abort_ff;
  assign o_lockup        = wd_fire;

endmodule : deia_unit

// >>> rtl/deia_cfg.svh
`ifndef DEIA_CFG_SVH
`define DEIA_CFG_SVH
`define DEIA_N_RES       8
`define DEIA_N_CH        4
`define DEIA_RES_W       3
`define DEIA_CH_W        2
`define DEIA_PC_W        32
`define DEIA_SEL_RST     8'h00
`define DEIA_IRQ_RST     8'h00
`define DEIA_EVT_RST     8'h00
`define DEIA_WD_IRQ_RST  1'b0
`define DEIA_WD_TIME_NS  160
`define DEIA_CLK_NS      10
`define DEIA_WD_CYCLES   (`DEIA_WD_TIME_NS / `DEIA_CLK_NS)
`endif

// >>> rtl/deia_pkg.sv
`include "deia_cfg.svh"
package deia_pkg;
  typedef enum logic [1:0] {
    DEIA_RUN       = 2'b00,
    DEIA_WAIT      = 2'b01,
    DEIA_FAULTING  = 2'b10,
    DEIA_FAULTED   = 2'b11
  } deia_chst_t;

  // one instruction slot per channel per cycle
  typedef struct packed {
    logic                     sev;
    logic                     wfe;
    logic [`DEIA_RES_W-1:0]   res;
    logic [`DEIA_PC_W-1:0]    pc;
  } deia_instr_t;

  typedef struct packed {
    logic ns_secure_txn;
    logic ns_secure_evt;
    logic ns_secure_periph;
    logic ns_mgr_start_secure;
    logic undef_instr;
    logic bad_operand;
    logic fetch_err;
    logic store_short;
  } deia_precise_t;

  typedef struct packed {
    logic load_err;
    logic store_err;
    logic fifo_too_small;
    logic store_no_load;
  } deia_imprecise_t;

  typedef struct packed {
    logic running;
    logic blocked_fifo;
    logic blocked_lock;
    logic bus_active;
  } deia_ldstat_t;
endpackage : deia_pkg

// >>> tb/deia_unit_assertions.sv
module deia_unit_chk
  import deia_pkg::*;
(
  input wire logic                i_clock,
  input wire logic                i_rst,
  input wire logic [7:0]          i_event_or_irq_select_reg,
  input wire logic [7:0]          i_interrupt_clear_reg,
  input wire deia_instr_t [3:0]   i_instr,
  input wire deia_precise_t [3:0] i_precise,
  input wire logic [3:0]          i_kill,
  input wire logic [7:0]          o_irq,
  input wire logic [7:0]          o_event_pending,
  input wire logic [3:0]          o_stall,
  input wire logic [3:0]          o_nop,
  input wire logic [3:0]          o_halt_issue,
  input wire logic [3:0]          o_faulted,
  input wire logic [3:0]          o_precise_fault,
  input wire logic [127:0]        o_fault_pc,
  input wire logic                o_abort_irq,
  input wire logic                o_lockup
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] r0;
  logic       go0;
  assign r0 = i_instr[0].res;
  assign go0 = !o_halt_issue[0] && !o_stall[0];
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  sequence s_pend_wfe;
    i_instr[0].wfe && o_event_pending[r0] && !o_halt_issue[0];
  endsequence
  sequence s_abort0;
    (|i_precise[0]) && go0;
  endsequence
  a_irq_level_hold: assert property (
    1 |=> &(o_irq | ~$past(o_irq) | $past(i_interrupt_clear_reg)))
    else $error("irq line dropped without clear");
  a_sev_irq_set: assert property (
    i_instr[0].sev && i_event_or_irq_select_reg[r0] && go0
    && !(|i_precise[0]) |=> o_irq[$past(r0)])
    else $error("send did not raise irq");
  a_event_no_irq: assert property (
    1 |=> (o_irq & ~$past(o_irq) & ~$past(i_event_or_irq_select_reg))
    == 8'h00) else $error("irq raised on event resource");
  a_precise_nop: assert property (s_abort0 |-> o_nop[0])
    else $error("precise abort without nop");
  a_fault_pc_load: assert property (
    s_abort0 |=> o_precise_fault[0]
    && o_fault_pc[31:0] == $past(i_instr[0].pc))
    else $error("fault pc not captured");
  a_abort_irq_set: assert property (
    s_abort0 |=> o_abort_irq && o_halt_issue[0])
    else $error("abort did not halt channel");
  a_lockup_irq: assert property (o_lockup |=> o_abort_irq)
    else $error("lockup without abort irq");
  a_abort_hold: assert property (
    o_abort_irq && (|o_faulted) && !(|i_kill) |=> o_abort_irq)
    else $error("abort irq dropped while faulted");
  a_pend_wait_one: assert property (
    s_pend_wfe |-> ##[1:2] !o_stall[0])
    else $error("pending wait stalled too long");
endmodule : deia_unit_chk

bind deia_unit deia_unit_chk chk_u (.i_clock(i_clock), .i_rst(i_rst),
  .i_event_or_irq_select_reg(i_event_or_irq_select_reg),
  .i_interrupt_clear_reg(i_interrupt_clear_reg), .i_instr(i_instr),
  .i_precise(i_precise), .i_kill(i_kill), .o_irq(o_irq),
  .o_event_pending(o_event_pending), .o_stall(o_stall), .o_nop(o_nop),
  .o_halt_issue(o_halt_issue), .o_faulted(o_faulted),
  .o_precise_fault(o_precise_fault), .o_fault_pc(o_fault_pc),
  .o_abort_irq(o_abort_irq), .o_lockup(o_lockup));

// >>> tb/deia_cpu_model.sv
module deia_cpu_model #(
  parameter int DLY = 4
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_irq,
  output logic      [7:0] o_clear = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // slow handler: lets the bench see the level stand first
  always @(posedge i_clock) begin
    if (i_rst || i_irq == 8'h00 || o_clear != 8'h00) begin
      cnt <= 0;
      o_clear <= 8'h00;
    end else if (cnt < DLY) begin
      cnt <= cnt + 1;
    end else begin
      o_clear <= i_irq;
    end
  end
endmodule : deia_cpu_model

// >>> tb/testbench.sv
module testbench
  import deia_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wfl = 1'b0;
  logic lqe = 1'b0;
  logic sqe = 1'b0;
  logic [7:0] sel = 8'h00;
  logic [3:0] kill = 4'h0;
  deia_instr_t [3:0] ins = '0;
  deia_precise_t [3:0] prec = '0;
  deia_ldstat_t [3:0] lds = '0;
  deia_imprecise_t [3:0] imp = '0;
  logic [7:0] clr, irq, pend;
  logic [3:0] stall, nop, halt, flt, pflt, stp;
  logic [127:0] fpc;
  logic airq, lock;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  deia_unit dut_u (.i_clock(clk), .i_rst(rst),
    .i_event_or_irq_select_reg(sel), .i_interrupt_clear_reg(clr),
    .i_watchdog_interrupt_only_flag(wfl), .i_instr(ins),
    .i_precise(prec), .i_imprecise(imp), .i_ldstat(lds),
    .i_load_queue_empty(lqe), .i_store_queue_empty(sqe), .i_kill(kill),
    .o_irq(irq), .o_event_pending(pend), .o_stall(stall), .o_nop(nop),
    .o_halt_issue(halt), .o_faulted(flt), .o_stopped(stp),
    .o_precise_fault(pflt), .o_fault_pc(fpc), .o_abort_irq(airq),
    .o_lockup(lock));
  deia_cpu_model cpu_u (.i_clock(clk), .i_rst(rst), .i_irq(irq),
    .o_clear(clr));
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask : chk
  task automatic rst_dut(input int n);
    @(posedge clk);
    rst <= 1'b1;
    {ins, prec, imp, lds, kill, wfl, lqe, sqe} <= '0;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
  endtask : rst_dut
  task automatic send(input int c, input logic s, w, input logic [2:0] r);
    @(posedge clk);
    ins[c] <= {s, w, r, 32'h0000_0100};
    @(posedge clk);
    ins[c] <= '0;
  endtask : send
  task automatic t_irq();
    int k = 0;
    rst_dut(2);
    sel <= 8'h0f;
    send(0, 1'b1, 1'b0, 3'd2); // queues not empty; the send does not wait on them
    @(negedge clk);
    chk("irq set", 8'h04, irq);
    send(1, 1'b0, 1'b1, 3'd2);
    @(negedge clk);
    chk("irq kept", 8'h04, irq);
    do @(negedge clk); while (irq !== 8'h00 && ++k < 12);
    chk("irq cleared", 8'h00, irq);
    send(0, 1'b1, 1'b0, 3'd5);
    @(negedge clk);
    chk("event kind", 8'h20, pend);
    chk("no irq", 8'h00, irq);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_evt();
    int k = 0;
    rst_dut(2);
    @(posedge clk);
    ins[1] <= {2'b01, 3'd5, 32'h0};
    ins[2] <= {2'b01, 3'd5, 32'h0};
    @(posedge clk);
    ins <= '0;
    repeat (2) @(negedge clk);
    chk("waiters", 4'h6, stall);
    send(0, 1'b1, 1'b0, 3'd5);
    do @(negedge clk); while (stall[1] !== 1'b0 && ++k < 3);
    chk("resume", 4'h0, stall);
    @(negedge clk);
    chk("evt gone", 8'h00, pend);
    $display("t_evt done");
  endtask : t_evt
  task automatic t_pend();
    rst_dut(2);
    send(0, 1'b1, 1'b0, 3'd6);
    @(negedge clk);
    chk("pending", 8'h40, pend);
    send(0, 1'b0, 1'b1, 3'd6);
    send(2, 1'b0, 1'b1, 3'd6);
    repeat (2) @(negedge clk);
    chk("one user", 4'h4, stall);
    chk("consumed", 8'h00, pend);
    @(posedge clk);
    ins[0] <= {2'b10, 3'd7, 32'h0};
    ins[1] <= {2'b01, 3'd7, 32'h0};
    @(posedge clk);
    ins <= '0;
    repeat (3) @(negedge clk);
    chk("same cycle", 4'h4, stall);
    chk("not left", 8'h00, pend);
    $display("t_pend done");
  endtask : t_pend
  task automatic t_abort(input int b);
    int k = 0;
    rst_dut(2);
    sel <= 8'hff;
    lds[0] <= 4'b1001;
    @(posedge clk);
    ins[0] <= {2'b10, 3'd0, 32'h0000_1234};
    prec[0] <= 8'h01 << b;
    @(negedge clk);
    chk("nop", 4'h1, nop);
    @(posedge clk);
    {ins, prec} <= '0;
    @(negedge clk);
    chk("pc", 32'h0000_1234, fpc[31:0]);
    chk("precise", 4'h1, pflt);
    chk("abort irq", 1, airq);
    chk("no send", 8'h00, irq);
    chk("draining", 4'h1, halt & ~flt);
    @(posedge clk);
    lds <= '0;
    do @(negedge clk); while (flt[0] !== 1'b1 && ++k < 4);
    chk("faulted", 4'h1, flt);
    @(posedge clk);
    kill <= 4'h1;
    @(posedge clk);
    kill <= 4'h0;
    repeat (2) @(negedge clk);
    chk("killed", 5'h00, {flt, airq});
    chk("stopped", 4'h1, stp);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_imp(input int b);
    rst_dut(2);
    @(posedge clk);
    ins[1] <= {2'b00, 3'd0, 32'h0000_2000};
    imp[1] <= 4'h1 << b;
    @(posedge clk);
    {ins, imp} <= '0;
    @(negedge clk);
    chk("imp pc", 32'h0000_2000, fpc[63:32]);
    chk("imp kind", 4'h0, pflt);
    chk("imp halt", 4'h2, halt);
    chk("imp irq", 1, airq);
    $display("t_imp done");
  endtask : t_imp
  task automatic t_lock(input logic f);
    int k = 0;
    rst_dut(2);
    {wfl, lqe, sqe} <= {f, 2'b11};
    lds <= {4'hc, 4'ha, 4'hc, 4'hc};
    do @(negedge clk); while (lock !== 1'b1 && ++k < 40);
    chk("lockup", 1, lock);
    @(negedge clk);
    chk("wd irq", 1, airq);
    chk("wd halt", f ? 4'h0 : 4'hf, halt);
    $display("t_lock done");
  endtask : t_lock
  task automatic wrap_up();
    $display("checked %0d bad %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    rst_dut(10);
    t_irq();
    t_evt();
    t_pend();
    for (int b = 0; b < 8; b++) t_abort(b);
    for (int b = 0; b < 4; b++) t_imp(b);
    t_lock(1'b0);
    t_lock(1'b1);
    wrap_up();
  end
endmodule : testbench
